// *** shared/rx_mac_pkg.sv ***
// Overview of operation
// - Pass-through mode delivers start, preamble and SFD.
// - Otherwise strip preamble; first flag on DA.
// - One setting drives RX and TX pass-through.
// - Expected terminate character raises last-beat flag.
// - Other control ends frame, fault bits 0,1.
// - No second last-beat after early end.
// - Injected error character marks frame malformed.
// - Ordered sets of any type are not errors.
// - Length/type below 0x600 is payload length.
// - Type 0x8100 is VLAN; keep checking lengths.
// - 0x8808 opcode 0x0001/0x0101 triggers pause, forwarded.
// - Other types forwarded unchanged.
// - Checked frames under 64 bytes are undersized.
// - Oversize limit: max, plus four, plus eight.
// - Count payload bytes, compare with length field.
// - Payload minimum 46/42/38, below 1536.
// - Bad lengths delivered, flagged bits 2,3,4.
// - Short payload errors; extra bytes are padding.
// - CRC fault bit on last beat, data delayed.
// - CRC stripped by default; software enables forwarding.
// - Last beat on final CRC or pre-CRC byte.
// - Standard CRC-32 over DA through pad.
package rx_mac_pkg;

  typedef enum logic [1:0]
  {
    S_IDLE  = 2'b00,
    S_PRE   = 2'b01,
    S_FRAME = 2'b10,
    S_DRAIN = 2'b11
  } rx_state_type;

  // ----------------------------------------
  // Link characters and frame layout
  // ----------------------------------------
  localparam logic [7:0]  CHAR_START     = 8'hFB;
  localparam logic [7:0]  CHAR_TERM      = 8'hFD;
  localparam logic [2:0]  PREAMBLE_LAST  = 3'h6;
  localparam logic [1:0]  DRAIN_LAST     = 2'h3;
  localparam logic [15:0] TYPE_LIMIT     = 16'h0600;
  localparam logic [15:0] TYPE_VLAN      = 16'h8100;
  localparam logic [15:0] TYPE_CONTROL   = 16'h8808;
  localparam logic [15:0] OPC_PAUSE      = 16'h0001;
  localparam logic [15:0] OPC_PFC        = 16'h0101;
  localparam logic [15:0] MIN_FRAME      = 16'h0040;
  localparam logic [15:0] HDR_BASIC      = 16'h000E;
  localparam logic [15:0] HDR_VLAN       = 16'h0012;
  localparam logic [15:0] HDR_STACKED    = 16'h0016;
  localparam logic [15:0] MINPL_BASIC    = 16'h002E;
  localparam logic [15:0] MINPL_VLAN     = 16'h002A;
  localparam logic [15:0] MINPL_STACKED  = 16'h0026;
  localparam logic [15:0] EXTRA_VLAN     = 16'h0004;
  localparam logic [15:0] EXTRA_STACKED  = 16'h0008;
  localparam logic [15:0] FCS_BYTES      = 16'h0004;
  localparam logic [31:0] CRC_POLY_REFL  = 32'hEDB8_8320;
  localparam logic [31:0] CRC_RESIDUE    = 32'hDEBB_20E3;

  // ----------------------------------------
  // Fault and status bit positions
  // ----------------------------------------
  localparam int ERR_MALFORMED  = 0;
  localparam int ERR_FCS        = 1;
  localparam int ERR_UNDERSIZE  = 2;
  localparam int ERR_OVERSIZE   = 3;
  localparam int ERR_PAYLOAD    = 4;
  localparam int STS_VLAN       = 0;
  localparam int STS_STACKED    = 1;
  localparam int STS_PAUSE      = 2;
  localparam int STS_PFC        = 3;
  localparam int STS_CONTROL    = 4;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_MAX_SIZE  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam int          CTRL_PREAMBLE  = 0;
  localparam int          CTRL_CRC_FWD   = 1;
  localparam int          STAT_ERR_LSB   = 0;
  localparam int          STAT_STS_LSB   = 8;
  localparam int          STAT_BUSY      = 16;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [15:0] MAX_SIZE_RESET = 16'h05EE;

endpackage

// *** src/rx_mac_frame_checker.sv ***
`timescale 1ns/1ps
module rx_mac_frame_checker
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  mii_data,
  input  wire logic        mii_ctrl,
  output logic      [7:0]  rx_data,
  output logic             rx_valid,
  output logic             rx_first_beat_flag,
  output logic             rx_last_beat_flag,
  output logic      [4:0]  rx_fault_vector,
  output logic      [4:0]  rx_frame_status_bus,
  output logic      [2:0]  rx_unused_byte_count,
  output logic             rx_pause_pulse,
  output logic             tx_preamble_pass
);

  typedef struct packed {
    rx_mac_pkg::rx_state_type st;
    logic [2:0]               pcnt;
    logic [15:0]              fcnt;
    logic [31:0]              crc;
    logic [15:0]              ltype;
    logic [15:0]              ctype;
    logic [15:0]              opc;
    logic                     vlan;
    logic                     svlan;
    logic [4:0][7:0]          sh;
    logic [4:0]               vld;
    logic [4:0]               sop;
    logic [1:0]               dcnt;
    logic [4:0]               err;
    logic [4:0]               sts;
    logic [7:0]               dat;
    logic                     ov;
    logic                     osop;
    logic                     oeop;
    logic [4:0]               oerr;
    logic [4:0]               osts;
    logic                     pause;
    logic [1:0]               ctrl;
    logic [15:0]              maxsz;
    logic [4:0]               last_err;
    logic [4:0]               last_sts;
    logic                     rdy;
    logic                     slverr;
    logic [31:0]              rdata;
  } regs_type;

  localparam regs_type REGS_RESET = '{st: rx_mac_pkg::S_IDLE, ctrl: rx_mac_pkg::CTRL_RESET,
                                      maxsz: rx_mac_pkg::MAX_SIZE_RESET, default: '0};

  regs_type q;
  regs_type n;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Bit-serial reflected CRC; the residue test over data plus FCS avoids a byte swap.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ rx_mac_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return a == rx_mac_pkg::ADDR_CTRL || a == rx_mac_pkg::ADDR_MAX_SIZE || a == rx_mac_pkg::ADDR_STATUS;
  endfunction

  // Returns {status, fault} for a frame that ended on a terminate character.
  function automatic logic [9:0] end_check(input regs_type c);
    logic [15:0] hdr;
    logic [15:0] minpl;
    logic [15:0] limit;
    logic [15:0] lenf;
    logic [15:0] actual;
    logic        checked;
    logic [4:0]  e;
    logic [4:0]  s;
    hdr     = c.svlan ? rx_mac_pkg::HDR_STACKED : (c.vlan ? rx_mac_pkg::HDR_VLAN : rx_mac_pkg::HDR_BASIC);
    minpl   = c.svlan ? rx_mac_pkg::MINPL_STACKED : (c.vlan ? rx_mac_pkg::MINPL_VLAN : rx_mac_pkg::MINPL_BASIC);
    limit   = c.maxsz + (c.svlan ? rx_mac_pkg::EXTRA_STACKED : (c.vlan ? rx_mac_pkg::EXTRA_VLAN : 16'h0000));
    lenf    = c.vlan ? c.ctype : c.ltype;
    checked = c.vlan || (c.ltype < rx_mac_pkg::TYPE_LIMIT);
    actual  = (c.fcnt > hdr + rx_mac_pkg::FCS_BYTES) ? c.fcnt - hdr - rx_mac_pkg::FCS_BYTES : 16'h0000;
    e = '0;
    s = '0;
    e[rx_mac_pkg::ERR_FCS]       = c.crc != rx_mac_pkg::CRC_RESIDUE;
    e[rx_mac_pkg::ERR_UNDERSIZE] = checked && c.fcnt < rx_mac_pkg::MIN_FRAME;
    e[rx_mac_pkg::ERR_OVERSIZE]  = checked && c.fcnt > limit;
    // Longer-than-declared payload is padding, so only the short side faults.
    e[rx_mac_pkg::ERR_PAYLOAD]   = checked && lenf < rx_mac_pkg::TYPE_LIMIT
                                   && (lenf > actual || lenf < minpl);
    s[rx_mac_pkg::STS_VLAN]      = c.vlan;
    s[rx_mac_pkg::STS_STACKED]   = c.svlan;
    s[rx_mac_pkg::STS_CONTROL]   = c.ltype == rx_mac_pkg::TYPE_CONTROL;
    s[rx_mac_pkg::STS_PAUSE]     = s[rx_mac_pkg::STS_CONTROL] && c.opc == rx_mac_pkg::OPC_PAUSE;
    s[rx_mac_pkg::STS_PFC]       = s[rx_mac_pkg::STS_CONTROL] && c.opc == rx_mac_pkg::OPC_PFC;
    return {s, e};
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic       push;
  logic [7:0] push_b;
  logic       push_v;
  logic       push_s;
  logic       set_eop;
  logic       clear_line;
  logic [4:0] eop_err;
  logic [4:0] eop_sts;
  logic [9:0] fin;
  logic       pass;
  logic       fwd;
  logic       is_term;
  logic       apb_acc;

  always_comb
  begin
    n          = q;
    push       = 1'b0;
    push_b     = 8'h00;
    push_v     = 1'b0;
    push_s     = 1'b0;
    set_eop    = 1'b0;
    clear_line = 1'b0;
    eop_err    = 5'h00;
    eop_sts    = 5'h00;
    fin        = end_check(q);
    pass       = q.ctrl[rx_mac_pkg::CTRL_PREAMBLE];
    fwd        = q.ctrl[rx_mac_pkg::CTRL_CRC_FWD];
    is_term    = mii_ctrl && mii_data == rx_mac_pkg::CHAR_TERM;
    n.ov       = 1'b0;
    n.osop     = 1'b0;
    n.oeop     = 1'b0;
    n.oerr     = 5'h00;
    n.osts     = 5'h00;
    n.pause    = 1'b0;
    case (q.st)
      rx_mac_pkg::S_IDLE:
      begin
        // Ordered sets, idles and stray terminates are dropped here without fault.
        if (mii_ctrl && mii_data == rx_mac_pkg::CHAR_START)
        begin
          n.st    = rx_mac_pkg::S_PRE;
          n.pcnt  = 3'h0;
          n.fcnt  = 16'h0000;
          n.crc   = 32'hFFFF_FFFF;
          n.ltype = 16'h0000;
          n.ctype = 16'h0000;
          n.opc   = 16'h0000;
          n.vlan  = 1'b0;
          n.svlan = 1'b0;
          if (pass)
          begin
            push   = 1'b1;
            push_b = mii_data;
            push_v = 1'b1;
            push_s = 1'b1;
          end
        end
      end
      rx_mac_pkg::S_PRE, rx_mac_pkg::S_FRAME:
      begin
        if (q.st == rx_mac_pkg::S_FRAME && is_term)
        begin
          push  = 1'b1;
          n.err = fin[4:0];
          n.sts = fin[9:5];
          if (fwd)
          begin
            n.st   = rx_mac_pkg::S_DRAIN;
            n.dcnt = rx_mac_pkg::DRAIN_LAST;
          end
          else
          begin
            set_eop    = 1'b1;
            eop_err    = fin[4:0];
            eop_sts    = fin[9:5];
            clear_line = 1'b1;
            n.st       = rx_mac_pkg::S_IDLE;
          end
        end
        else if (mii_ctrl)
        begin
          // Error, start, idle or any other control ends the frame as malformed.
          push       = 1'b1;
          set_eop    = 1'b1;
          eop_err[rx_mac_pkg::ERR_MALFORMED] = 1'b1;
          eop_err[rx_mac_pkg::ERR_FCS]       = 1'b1;
          clear_line = 1'b1;
          n.st       = rx_mac_pkg::S_IDLE;
        end
        else if (q.st == rx_mac_pkg::S_PRE)
        begin
          push   = pass;
          push_b = mii_data;
          push_v = 1'b1;
          n.pcnt = q.pcnt + 3'h1;
          if (q.pcnt == rx_mac_pkg::PREAMBLE_LAST)
          begin
            n.st = rx_mac_pkg::S_FRAME;
          end
        end
        else
        begin
          push   = 1'b1;
          push_b = mii_data;
          push_v = 1'b1;
          push_s = !pass && q.fcnt == 16'h0000;
          n.crc  = crc_byte(q.crc, mii_data);
          n.fcnt = (q.fcnt == 16'hFFFF) ? q.fcnt : q.fcnt + 16'h0001;
          case (q.fcnt)
            16'h000C: n.ltype[15:8] = mii_data;
            16'h000D: n.ltype[7:0]  = mii_data;
            16'h000E:
            begin
              n.opc[15:8] = mii_data;
              n.vlan      = q.ltype == rx_mac_pkg::TYPE_VLAN;
            end
            16'h000F: n.opc[7:0]    = mii_data;
            16'h0010: n.ctype[15:8] = mii_data;
            16'h0011: n.ctype[7:0]  = mii_data;
            16'h0012: n.svlan       = q.vlan && q.ctype == rx_mac_pkg::TYPE_VLAN;
            16'h0014: n.ctype[15:8] = q.svlan ? mii_data : q.ctype[15:8];
            16'h0015: n.ctype[7:0]  = q.svlan ? mii_data : q.ctype[7:0];
            default: ;
          endcase
        end
      end
      rx_mac_pkg::S_DRAIN:
      begin
        push   = 1'b1;
        n.dcnt = q.dcnt - 2'h1;
        if (q.dcnt == 2'h0)
        begin
          set_eop    = 1'b1;
          eop_err    = q.err;
          eop_sts    = q.sts;
          clear_line = 1'b1;
          n.st       = rx_mac_pkg::S_IDLE;
        end
      end
      default: n.st = rx_mac_pkg::S_IDLE;
    endcase

    // Five-byte line: the four newest bytes may be FCS, so nothing leaves until it is known.
    if (push)
    begin
      n.dat  = q.sh[4];
      n.ov   = q.vld[4];
      n.osop = q.sop[4];
      n.sh   = {q.sh[3:0], push_b};
      n.vld  = {q.vld[3:0], push_v};
      n.sop  = {q.sop[3:0], push_s};
    end
    if (clear_line)
    begin
      n.vld = 5'h00;
      n.sop = 5'h00;
    end
    if (set_eop && q.vld[4])
    begin
      n.oeop     = 1'b1;
      n.oerr     = eop_err;
      n.osts     = eop_sts;
      n.pause    = eop_sts[rx_mac_pkg::STS_PAUSE] | eop_sts[rx_mac_pkg::STS_PFC];
      n.last_err = eop_err;
      n.last_sts = eop_sts;
    end

    // APB slave: one wait state; writes land on the edge that completes the access.
    apb_acc  = psel && penable;
    n.rdy    = apb_acc && !q.rdy;
    n.slverr = 1'b0;
    if (apb_acc && !q.rdy)
    begin
      n.slverr = !reg_mapped(paddr);
      n.rdata  = 32'h0000_0000;
      if (!pwrite && paddr == rx_mac_pkg::ADDR_CTRL)
      begin
        n.rdata[1:0] = q.ctrl;
      end
      if (!pwrite && paddr == rx_mac_pkg::ADDR_MAX_SIZE)
      begin
        n.rdata[15:0] = q.maxsz;
      end
      if (!pwrite && paddr == rx_mac_pkg::ADDR_STATUS)
      begin
        n.rdata[rx_mac_pkg::STAT_ERR_LSB +: 5] = q.last_err;
        n.rdata[rx_mac_pkg::STAT_STS_LSB +: 5] = q.last_sts;
        n.rdata[rx_mac_pkg::STAT_BUSY]         = q.st != rx_mac_pkg::S_IDLE;
      end
    end
    if (apb_acc && q.rdy && pwrite)
    begin
      if (paddr == rx_mac_pkg::ADDR_CTRL && pstrb[0])
      begin
        n.ctrl = pwdata[1:0];
      end
      if (paddr == rx_mac_pkg::ADDR_MAX_SIZE)
      begin
        n.maxsz[7:0]  = pstrb[0] ? pwdata[7:0] : q.maxsz[7:0];
        n.maxsz[15:8] = pstrb[1] ? pwdata[15:8] : q.maxsz[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= REGS_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Beats are one byte wide, so the unused byte count stays zero.
  assign prdata               = q.rdata;
  assign pready               = q.rdy;
  assign pslverr              = q.slverr;
  assign rx_data              = q.dat;
  assign rx_valid             = q.ov;
  assign rx_first_beat_flag   = q.osop;
  assign rx_last_beat_flag    = q.oeop;
  assign rx_fault_vector      = q.oerr;
  assign rx_frame_status_bus  = q.osts;
  assign rx_unused_byte_count = 3'h0;
  assign rx_pause_pulse       = q.pause;
  assign tx_preamble_pass     = q.ctrl[rx_mac_pkg::CTRL_PREAMBLE];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence strip_start_s;
    q.st == rx_mac_pkg::S_IDLE && mii_ctrl && mii_data == rx_mac_pkg::CHAR_START
      && !q.ctrl[rx_mac_pkg::CTRL_PREAMBLE];
  endsequence

  sequence pass_start_s;
    q.st == rx_mac_pkg::S_IDLE && mii_ctrl && mii_data == rx_mac_pkg::CHAR_START
      && q.ctrl[rx_mac_pkg::CTRL_PREAMBLE];
  endsequence

  sequence fwd_term_s;
    q.st == rx_mac_pkg::S_FRAME && is_term && q.ctrl[rx_mac_pkg::CTRL_CRC_FWD] && q.vld[0];
  endsequence

  strip_sop_a: assert property (strip_start_s ##1 (!mii_ctrl)[*8] ##1 (!mii_ctrl)[*5]
                                |=> rx_first_beat_flag && rx_valid)
    else $error("first beat not on destination address");

  pass_sop_a: assert property (pass_start_s ##1 (!mii_ctrl)[*5]
                               |=> rx_first_beat_flag && rx_data == rx_mac_pkg::CHAR_START)
    else $error("start byte not delivered first");

  term_eop_a: assert property (q.st == rx_mac_pkg::S_FRAME && is_term && !fwd && q.vld[4]
                               |=> rx_last_beat_flag && rx_valid)
    else $error("terminate did not end the frame");

  fwd_drain_a: assert property (fwd_term_s |=> (!rx_last_beat_flag)[*4] ##1 rx_last_beat_flag)
    else $error("forwarded CRC end misplaced");

  bad_ctrl_a: assert property (q.st == rx_mac_pkg::S_FRAME && mii_ctrl && !is_term && q.vld[4]
                               |=> rx_last_beat_flag && rx_fault_vector[1:0] == 2'b11)
    else $error("malformed frame not flagged");

  single_eop_a: assert property (rx_last_beat_flag && q.st == rx_mac_pkg::S_IDLE && is_term
                                 |=> !rx_last_beat_flag)
    else $error("second end after early end");

  fault_gate_a: assert property (!rx_last_beat_flag |-> rx_fault_vector == 5'h00)
    else $error("fault bits outside last beat");

  pause_ties_a: assert property (rx_pause_pulse
                                 |-> rx_last_beat_flag && (rx_frame_status_bus[2] || rx_frame_status_bus[3]))
    else $error("pause pulse without pause frame end");

endmodule

// *** test/rx_client_model.sv ***
`timescale 1ns/1ps
module rx_client_model
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_first_beat_flag,
  input wire logic       rx_last_beat_flag,
  input wire logic [4:0] rx_fault_vector,
  input wire logic [4:0] rx_frame_status_bus,
  input wire logic       rx_pause_pulse
);
  logic [7:0] got_q[$];
  logic [4:0] fault_seen;
  logic [4:0] status_seen;
  logic       pause_seen;
  int         n_last = 0;
  int         n_stray = 0;

  // Faults and status mean something only on the last beat.
  always @(posedge pclk)
  begin
    if (rx_valid && rx_first_beat_flag)
      got_q = {};
    if (rx_valid)
      got_q.push_back(rx_data);
    if (rx_valid && rx_last_beat_flag)
    begin
      n_last++;
      fault_seen = rx_fault_vector;
      status_seen = rx_frame_status_bus;
      pause_seen = rx_pause_pulse;
    end
    else if (presetn && (rx_fault_vector !== 5'h00 || rx_frame_status_bus !== 5'h00 || rx_pause_pulse !== 1'b0))
      n_stray++;
  end
endmodule

// *** test/rx_mac_frame_checker_tb_top.sv ***
`timescale 1ns/1ps
module rx_mac_frame_checker_tb_top;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  mii_data = 8'h07;
  logic        mii_ctrl = 1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_first_beat_flag;
  logic        rx_last_beat_flag;
  logic [4:0]  rx_fault_vector;
  logic [4:0]  rx_frame_status_bus;
  logic [2:0]  rx_unused_byte_count;
  logic        rx_pause_pulse;
  logic        tx_preamble_pass;
  logic [7:0]  fr[$];
  logic [31:0] rd;
  logic        err;
  logic        pt = 0;
  logic        fwd = 0;
  logic [15:0] max_size = 16'h05EE;
  logic [9:0]  last_e;
  logic [15:0] l;
  logic [15:0] opc[3] = '{16'h0001, 16'h0101, 16'h0002};
  int          n;
  int          n_mismatch = 0;
  int          compares = 0;

  rx_mac_frame_checker uut (.*);
  rx_client_model client (.*);

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Bus, link and checking tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_mismatch++;
      $display("ERROR apb pready expected 1 seen 0");
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic set_ctrl(input logic p, input logic f);
    apb(1, 8'h00, {30'h0000_0000, f, p});
    pt = p;
    fwd = f;
  endtask

  task automatic set_max(input logic [15:0] m);
    apb(1, 8'h04, {16'h0000, m});
    max_size = m;
  endtask

  task automatic drive(input logic c, input logic [7:0] d);
    @(posedge pclk);
    mii_ctrl <= c;
    mii_data <= d;
  endtask

  function automatic logic [31:0] crc32(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (b[i])
    begin
      c = c ^ {24'h00_0000, b[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic make(input logic [15:0] t1, input logic [15:0] t2, input int np);
    fr = {};
    repeat (12) fr.push_back(8'($urandom));
    fr.push_back(t1[15:8]);
    fr.push_back(t1[7:0]);
    if (t1 == 16'h8100)
      fr.push_back(8'h00);
    if (t1 == 16'h8100)
      fr.push_back(8'h05);
    if (t1 == 16'h8100 || t1 == 16'h8808)
      fr.push_back(t2[15:8]);
    if (t1 == 16'h8100 || t1 == 16'h8808)
      fr.push_back(t2[7:0]);
    repeat (np) fr.push_back(8'($urandom));
  endtask

  // Status in the upper five bits, faults in the lower five.
  function automatic logic [9:0] expect_fs(input logic bad);
    logic [4:0]  f;
    logic [4:0]  s;
    logic [15:0] t;
    logic [15:0] lf;
    logic [15:0] oc;
    int          hdr;
    int          tot;
    f = 5'h00;
    s = 5'h00;
    f[1] = bad;
    t = {fr[12], fr[13]};
    tot = fr.size() + 4;
    s[0] = (t == 16'h8100);
    s[1] = s[0] && {fr[16], fr[17]} == 16'h8100;
    hdr = s[1] ? 22 : (s[0] ? 18 : 14);
    lf = {fr[hdr-2], fr[hdr-1]};
    oc = {fr[14], fr[15]};
    s[4] = (t == 16'h8808);
    s[2] = s[4] && oc == 16'h0001;
    s[3] = s[4] && oc == 16'h0101;
    if (t < 16'h0600 || s[0])
    begin
      f[2] = tot < 64;
      f[3] = tot > max_size + (s[1] ? 8 : (s[0] ? 4 : 0));
      f[4] = lf < 16'h0600 && (lf > fr.size() - hdr || lf < (s[1] ? 38 : (s[0] ? 42 : 46)));
    end
    return {s, f};
  endfunction

  task automatic run(input string name, input logic bad, input int mal);
    logic [7:0]  x[$];
    logic [31:0] c;
    int          n0;
    int          k;
    int          nb;
    c = crc32(fr) ^ {31'h0000_0000, bad};
    last_e = expect_fs(bad);
    x = fr;
    for (int i = 0; i < 4; i++)
      x.push_back(c[8*i +: 8]);
    n0 = client.n_last;
    drive(1, 8'hFB);
    repeat (6) drive(0, 8'h55);
    drive(0, 8'hD5);
    foreach (x[i])
      drive(i == mal, i == mal ? 8'hFE : x[i]);
    drive(1, 8'hFD);
    drive(1, 8'h9C);
    drive(1, 8'h07);
    k = 0;
    while (client.n_last == n0 && k < 40)
    begin
      @(posedge pclk);
      k++;
    end
    // The extra wait lets a wrongly repeated end show up.
    repeat (12) @(posedge pclk);
    chk({name, " last count"}, n0 + 1, client.n_last);
    if (mal >= 0)
      last_e = 10'h003;
    chk({name, " fault"}, last_e[4:0], client.fault_seen);
    if (mal < 0)
    begin
      chk({name, " status"}, last_e[9:5], client.status_seen);
      chk({name, " pause"}, last_e[7] | last_e[8], client.pause_seen);
      if (!fwd)
        x = fr;
      if (pt)
      begin
        x.push_front(8'hD5);
        repeat (6) x.push_front(8'h55);
        x.push_front(8'hFB);
      end
      nb = 0;
      foreach (x[i])
        nb += (client.got_q[i] !== x[i]);
      chk({name, " size"}, x.size(), client.got_q.size());
      chk({name, " bytes"}, 0, nb);
    end
    $display("test %s done", name);
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(16773));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h00, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(0, 8'h04, 32'h0000_0000);
    chk("max reset", 32'h0000_05EE, rd);
    apb(1, 8'h0C, 32'h0000_0003);
    chk("unmapped", 32'h0000_0001, {31'h0000_0000, err});
    pstrb <= 4'h0;
    apb(1, 8'h00, 32'h0000_0003);
    pstrb <= 4'hF;
    apb(0, 8'h00, 32'h0000_0000);
    chk("strobe off", 32'h0000_0000, rd);
    make(16'h002E, 16'h0000, 46);
    run("basic", 0, -1);
    apb(0, 8'h08, 32'h0000_0000);
    chk("status reg", {19'h0_0000, last_e[9:5], 3'h0, last_e[4:0]}, rd);
    make(16'h002E, 16'h0000, 45);
    run("undersize", 0, -1);
    make(16'h0030, 16'h0000, 46);
    run("long field", 0, -1);
    make(16'h002E, 16'h0000, 60);
    run("padding", 0, -1);
    make(16'h0800, 16'h0000, 50);
    run("bad fcs", 1, -1);
    run("malformed", 0, 20);
    run("malformed end", 0, fr.size() + 3);
    foreach (opc[i])
    begin
      make(16'h8808, opc[i], 44);
      run("control", 0, -1);
    end
    set_max(16'h0064);
    for (n = 82; n < 84; n++)
    begin
      make(16'h8100, 16'h0052, n);
      run("vlan size", 0, -1);
      make(16'h0052, 16'h0000, n);
      run("basic size", 0, -1);
    end
    set_max(16'h05EE);
    make(16'h8100, 16'h8100, 52);
    fr[20] = 8'h00;
    fr[21] = 8'h30;
    run("stacked", 0, -1);
    set_ctrl(0, 1);
    make(16'h002E, 16'h0000, 46);
    run("crc fwd", 0, -1);
    set_ctrl(1, 0);
    @(posedge pclk);
    chk("tx pass", 32'h0000_0001, {31'h0000_0000, tx_preamble_pass});
    run("preamble", 0, -1);
    for (int i = 0; i < 20; i++)
    begin
      set_ctrl(0, 1'($urandom));
      n = 30 + $urandom % 80;
      l = 16'(n + $urandom % 3) - 16'h0001;
      case ($urandom % 4)
        0: make(l, 16'h0000, n);
        1: make(16'h0800, 16'h0000, n);
        2: make(16'h8100, l, n);
        default: make(16'h8808, 16'h0001, n);
      endcase
      run("random", $urandom % 4 == 0, -1);
    end
    chk("unused count", 32'h0000_0000, {29'h0000_0000, rx_unused_byte_count});
    chk("stray beats", 32'h0000_0000, client.n_stray);
    summarize();
  end

  // A full run takes a few thousand cycles; this limit is far beyond it.
  initial
  begin
    #300_000;
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end
endmodule
